/* rtl/rsam_bit_gate.sv */
`timescale 1ns/1ps
`default_nettype none
module rsam_bit_gate #(
  parameter int unsigned W = 14
) (
  input  wire logic [W-1:0] i_valid,
  input  wire logic [W-1:0] i_allow,
  output logic      [W-1:0] o_rank_ok
);
  // an input enters ranking only when monitored valid and allowed
  assign o_rank_ok = i_valid & i_allow;
endmodule
`default_nettype wire

/* rtl/rsam_pkg.sv */
`default_nettype none
package rsam_pkg;

  localparam int unsigned NUM_INPUTS = 14;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned LOW_W      = 8;
  localparam int unsigned HIGH_W     = 6;

  localparam logic [7:0] ADDR_MASK_LOW  = 8'h30;
  localparam logic [7:0] ADDR_MASK_HIGH = 8'h31;

  localparam logic [7:0] RST_MASK_LOW   = 8'hff;
  localparam logic [5:0] RST_MASK_HIGH  = 6'h3f;

  localparam logic [1:0] HIGH_PAD       = 2'h0;
  localparam logic [7:0] RD_IDLE        = 8'h00;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rsam_req_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic       hit;
  } rsam_rsp_t;

endpackage
`default_nettype wire

/* rtl/rsam_top.sv */
`timescale 1ns/1ps
`default_nettype none
module rsam_top #(
  parameter int unsigned N = rsam_pkg::NUM_INPUTS
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_arst_n,
  input  wire logic                      i_ce,
  input  wire rsam_pkg::rsam_req_t       i_req,
  input  wire logic [N-1:0]              i_src_valid,
  output logic      [rsam_pkg::DATA_W-1:0] o_rdata,
  output logic                           o_rvalid,
  output logic      [N-1:0]              o_allow_mask,
  output logic      [N-1:0]              o_rank_ok
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic [1:0] rst_sync_r;
  logic       rst_n;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // mask registers
  logic [rsam_pkg::LOW_W-1:0]  mask_low_r;
  logic [rsam_pkg::HIGH_W-1:0] mask_high_r;
  logic                        wr_low;
  logic                        wr_high;

  assign wr_low  = i_req.wr && (i_req.addr == rsam_pkg::ADDR_MASK_LOW);
  assign wr_high = i_req.wr && (i_req.addr == rsam_pkg::ADDR_MASK_HIGH);

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_low_r <= rsam_pkg::RST_MASK_LOW;
    end else if (i_ce && wr_low) begin
      mask_low_r <= i_req.wdata;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_high_r <= rsam_pkg::RST_MASK_HIGH;
    end else if (i_ce && wr_high) begin
      mask_high_r <= i_req.wdata[rsam_pkg::HIGH_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path
  rsam_pkg::rsam_rsp_t rsp;

  always_comb begin
    rsp.hit   = 1'b1;
    rsp.rdata = rsam_pkg::RD_IDLE;
    case (i_req.addr)
      rsam_pkg::ADDR_MASK_LOW:  rsp.rdata = mask_low_r;
      rsam_pkg::ADDR_MASK_HIGH: rsp.rdata = {rsam_pkg::HIGH_PAD, mask_high_r};
      default:                  rsp.hit   = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata  <= rsam_pkg::RD_IDLE;
      o_rvalid <= 1'b0;
    end else if (i_ce) begin
      o_rvalid <= i_req.rd;
      o_rdata  <= (i_req.rd && rsp.hit) ? rsp.rdata : rsam_pkg::RD_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ranking qualification
  logic [N-1:0] allow;
  logic [N-1:0] rank_ok;

  assign allow = {mask_high_r, mask_low_r};

  rsam_bit_gate #(
    .W (N)
  ) u_gate (
    .i_valid   (i_src_valid),
    .i_allow   (allow),
    .o_rank_ok (rank_ok)
  );

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_allow_mask <= '0;
      o_rank_ok    <= '0;
    end else if (i_ce) begin
      o_allow_mask <= allow;
      o_rank_ok    <= rank_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_block_masked;
    @(posedge i_clk) disable iff (!rst_n)
    (i_ce && !allow[0]) |=> !o_rank_ok[0];
  endproperty
  a_block_masked: assert property (p_block_masked) else $error("masked input ranked");

  property p_pass_allowed;
    @(posedge i_clk) disable iff (!rst_n)
    (i_ce && allow[N-1] && i_src_valid[N-1]) |=> o_rank_ok[N-1];
  endproperty
  a_pass_allowed: assert property (p_pass_allowed) else $error("allowed input dropped");

  property p_low_write;
    @(posedge i_clk) disable iff (!rst_n)
    (i_ce && wr_low) |=> (mask_low_r == $past(i_req.wdata));
  endproperty
  a_low_write: assert property (p_low_write) else $error("low mask not written");

  property p_high_write;
    @(posedge i_clk) disable iff (!rst_n)
    (i_ce && wr_high) |=> (mask_high_r == $past(i_req.wdata[rsam_pkg::HIGH_W-1:0]));
  endproperty
  a_high_write: assert property (p_high_write) else $error("high mask not written");

  property p_high_pad;
    @(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_req.rd && i_req.addr == rsam_pkg::ADDR_MASK_HIGH) |=>
      (o_rdata[rsam_pkg::DATA_W-1:rsam_pkg::HIGH_W] == rsam_pkg::HIGH_PAD);
  endproperty
  a_high_pad: assert property (p_high_pad) else $error("unused bits not zero");

  property p_bit_map;
    @(posedge i_clk) disable iff (!rst_n)
    i_ce |=> (o_allow_mask[rsam_pkg::LOW_W] == $past(mask_high_r[0]) &&
              o_allow_mask[0] == $past(mask_low_r[0]));
  endproperty
  a_bit_map: assert property (p_bit_map) else $error("mask bit order wrong");

  property p_hold_mask;
    @(posedge i_clk) disable iff (!rst_n)
    !(wr_low && i_ce) |=> $stable(mask_low_r);
  endproperty
  a_hold_mask: assert property (p_hold_mask) else $error("low mask changed unwritten");

  property p_read_low;
    @(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_req.rd && i_req.addr == rsam_pkg::ADDR_MASK_LOW) |=>
      (o_rvalid && o_rdata == $past(mask_low_r));
  endproperty
  a_read_low: assert property (p_read_low) else $error("low readback wrong");

  property p_hold_high;
    @(posedge i_clk) disable iff (!rst_n)
    !(wr_high && i_ce) |=> $stable(mask_high_r);
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("high mask changed unwritten");

  property p_read_high;
    @(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_req.rd && i_req.addr == rsam_pkg::ADDR_MASK_HIGH) |=>
      (o_rvalid && o_rdata == {rsam_pkg::HIGH_PAD, $past(mask_high_r)});
  endproperty
  a_read_high: assert property (p_read_high) else $error("high readback wrong");

  // unmapped addresses answer zero and never touch the mask
  property p_read_miss;
    @(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_req.rd && i_req.addr != rsam_pkg::ADDR_MASK_LOW &&
      i_req.addr != rsam_pkg::ADDR_MASK_HIGH) |=> (o_rvalid && o_rdata == rsam_pkg::RD_IDLE);
  endproperty
  a_read_miss: assert property (p_read_miss) else $error("unmapped read not zero");

  property p_write_miss;
    @(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_req.wr && i_req.addr != rsam_pkg::ADDR_MASK_LOW &&
      i_req.addr != rsam_pkg::ADDR_MASK_HIGH) |=> ($stable(mask_low_r) && $stable(mask_high_r));
  endproperty
  a_write_miss: assert property (p_write_miss) else $error("unmapped write landed");

  property p_rvalid_pulse;
    @(posedge i_clk) disable iff (!rst_n)
    (i_ce && !i_req.rd) |=> !o_rvalid;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid without read");

  // a low clock enable must hold both mask registers and every output register
  property p_freeze;
    @(posedge i_clk) disable iff (!rst_n)
    !i_ce |=> ($stable(mask_low_r) && $stable(mask_high_r) && $stable(o_rvalid) &&
      $stable(o_rdata) && $stable(o_allow_mask) && $stable(o_rank_ok));
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with enable low");

  property p_rank_map;
    @(posedge i_clk) disable iff (!rst_n)
    i_ce |=> (o_rank_ok == ($past(i_src_valid) & $past(allow)));
  endproperty
  a_rank_map: assert property (p_rank_map) else $error("ranking set wrong");

  property p_top_masked;
    @(posedge i_clk) disable iff (!rst_n)
    (i_ce && !allow[N-1]) |=> !o_rank_ok[N-1];
  endproperty
  a_top_masked: assert property (p_top_masked) else $error("masked top input ranked");

  property p_top_bit;
    @(posedge i_clk) disable iff (!rst_n)
    i_ce |=> (o_allow_mask[N-1] == $past(mask_high_r[rsam_pkg::HIGH_W-1]));
  endproperty
  a_top_bit: assert property (p_top_bit) else $error("top input bit misplaced");

  property p_low_top_bit;
    @(posedge i_clk) disable iff (!rst_n)
    i_ce |=> (o_allow_mask[rsam_pkg::LOW_W-1] == $past(mask_low_r[rsam_pkg::LOW_W-1]));
  endproperty
  a_low_top_bit: assert property (p_low_top_bit) else $error("low top bit misplaced");

endmodule
`default_nettype wire

/* testbench/remote_source_allow_mask_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module remote_source_allow_mask_bench;
  logic                i_clk       = 1'b0;
  logic                i_arst_n    = 1'b0;
  logic                i_ce        = 1'b1;
  rsam_pkg::rsam_req_t i_req       = '0;
  logic [13:0]         i_src_valid = 14'h0000;
  logic [7:0]          o_rdata;
  logic                o_rvalid;
  logic [13:0]         o_allow_mask;
  logic [13:0]         o_rank_ok;
  int                  error_cnt   = 0;
  int                  comparisons = 0;
  logic [31:0]         lfsr        = 32'h63e1;
  logic [13:0]         mdl         = 14'h3fff;
  always #2 i_clk = ~i_clk;
  rsam_top dut_u (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_req(i_req),
    .i_src_valid(i_src_valid), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_allow_mask(o_allow_mask), .o_rank_ok(o_rank_ok));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp_rd(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t rd got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_mask(input logic [13:0] got, input logic [13:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t mask got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // one-cycle strobe; the answer is sampled at the following falling edge
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    i_req = '{wr: w, rd: r, addr: a, wdata: d};
    @(negedge i_clk);
    i_req = '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
    if (a == 8'h30) mdl[7:0] = d;
    if (a == 8'h31) mdl[13:8] = d[5:0];
  endtask
  task automatic rd(input logic [7:0] a);
    logic [7:0] e;
    e = (a == 8'h30) ? mdl[7:0] : (a == 8'h31) ? {2'h0, mdl[13:8]} : 8'h00;
    bus(1'b0, 1'b1, a, 8'h00);
    cmp_rd({o_rvalid, o_rdata}, {1'b1, e});
  endtask
  task automatic chk_mask;
    lfsr = nxt(lfsr);
    @(negedge i_clk);
    i_src_valid = lfsr[13:0];
    repeat (2) @(negedge i_clk);
    cmp_mask(o_allow_mask, mdl);
    cmp_mask(o_rank_ok, mdl & i_src_valid);
    cmp_rd({o_rvalid, o_rdata}, 9'h000);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(negedge i_clk);
    i_arst_n = 1'b1;
    repeat (3) @(negedge i_clk);
    rd(8'h30);
    rd(8'h31);
    chk_mask;
    $display("reset values done");
    for (int k = 0; k < 24; k++) begin
      lfsr = nxt(lfsr);
      wr({7'h18, lfsr[8]}, lfsr[7:0]);
      rd(8'h30);
      rd(8'h31);
      chk_mask;
    end
    $display("random masks done");
    for (int k = 0; k < 4; k++) begin
      lfsr = nxt(lfsr);
      wr(8'h30, ~lfsr[7:0]);
      wr(8'h31, {2'h0, ~lfsr[13:8]});
      chk_mask;
    end
    $display("partner exclusion done");
    wr(8'h30, 8'h00);
    wr(8'h31, 8'hc0);
    rd(8'h31);
    chk_mask;
    lfsr = nxt(lfsr);
    bus(1'b1, 1'b1, 8'h30, lfsr[7:0]);
    cmp_rd({o_rvalid, o_rdata}, {1'b1, mdl[7:0]});
    mdl[7:0] = lfsr[7:0];
    rd(8'h30);
    wr(8'h30, 8'ha5);
    wr(8'h32, 8'h5a);
    rd(8'h32);
    i_ce = 1'b0;
    i_src_valid = ~i_src_valid;
    bus(1'b1, 1'b0, 8'h30, 8'hff);
    cmp_rd({o_rvalid, o_rdata}, 9'h100);
    cmp_mask(o_rank_ok, mdl & ~i_src_valid);
    i_ce = 1'b1;
    rd(8'h30);
    chk_mask;
    $display("edge cases done");
    i_arst_n = 1'b0;
    mdl = 14'h3fff;
    @(negedge i_clk);
    cmp_mask(o_allow_mask, 14'h0000);
    cmp_rd({o_rvalid, o_rdata}, 9'h000);
    i_arst_n = 1'b1;
    repeat (3) @(negedge i_clk);
    rd(8'h30);
    rd(8'h31);
    chk_mask;
    $display("mid-run reset done");
    close_out;
  end
endmodule
`default_nettype wire
